// ==== hdl/bridge_defines.vh ====
/*
 * Constants for the parallel port to instrument bus bridge: register
 * offsets, control and status bit positions, and timing counts.
 * Assumes a 125 MHz core clock.
 */
`ifndef BRIDGE_DEFINES_VH
`define BRIDGE_DEFINES_VH

// Register offsets from the base I/O address
`define OFS_DATA 2'h0
`define OFS_STATUS 2'h1
`define OFS_CONTROL 2'h2

// Control register bit positions (bits 7..5 carry nothing)
`define CTL_STROBE 0
`define CTL_AUTO_LINEFEED 1
`define CTL_INIT 2
`define CTL_SELECT_INPUT 3
`define CTL_INTERRUPT_ENABLE 4

// Status register bit positions (bits 2..0 read as zero)
`define STS_ERROR_N 3
`define STS_SELECT 4
`define STS_PAPER_ERROR 5
`define STS_ACK_N 6
`define STS_BUSY_N 7

// Reset values
`define DATA_RESET 8'h00
`define CONTROL_RESET 8'h00
`define READ_ZERO 8'h00

// Listen address group: primary address ORed into this base
`define LISTEN_BASE 3'h1

// Timing
`define CLK_PERIOD_NS 8
`define ACK_MIN_NS 5000
`define ACK_CYCLES ((`ACK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_MIN_NS 500
`define SETTLE_CYCLES ((`SETTLE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hdl/byte_buffer2.v ====
/*
 * Two-entry byte buffer with valid/ready on both sides.
 * Assumes one synchronous active-high reset on the same clock.
 */
`default_nettype none

module byte_buffer2 (
   input wire i_core_clk,
   input wire i_rst,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [7:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [7:0] o_out_data
);

   reg [7:0] mem [0:1];
   reg wr_ptr;
   reg rd_ptr;
   reg [1:0] count;
   wire push;
   wire pop;

   // Full and empty come straight from the entry count
   assign o_in_ready = (count != 2'h2);
   assign o_out_valid = (count != 2'h0);
   assign o_out_data = mem[rd_ptr];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   // Pointers and count; simultaneous push and pop keep the count
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push & ~pop) begin
            count <= count + 2'h1;
         end else if (pop & ~push) begin
            count <= count - 2'h1;
         end
      end
   end

   // Storage needs no reset; valid guards every read
   always @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

endmodule // byte_buffer2

`default_nettype wire

// ==== hdl/parallel_port_gpib_bridge.v ====
/*
 * Parallel port emulator that forwards bytes to a listener on the
 * instrument bus: data, status and printer_control registers on a
 * byte-wide I/O port, a source handshake engine and the acknowledge
 * pulse. Assumes I/O strobes are synchronous one-cycle pulses, and
 * bus lines are logical levels (1 = asserted); the board converts
 * to the wire's negative logic and open-collector drive.
 */
`default_nettype none
`include "bridge_defines.vh"

module parallel_port_gpib_bridge (
   input wire i_core_clk,
   input wire i_rst,
   input wire [1:0] i_io_addr,
   input wire i_io_wr,
   input wire i_io_rd,
   input wire [7:0] i_io_wdata,
   output reg [7:0] o_io_rdata,
   output reg o_irq,
   input wire [4:0] i_printer_addr,
   input wire i_srq_option,
   input wire i_srq,
   input wire i_nrfd,
   input wire i_ndac,
   output reg [7:0] o_dio_out,
   output reg o_dio_oe,
   output reg o_atn,
   output reg o_dav
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_SETTLE = 3'h1;
   localparam [2:0] ST_WAIT_RFD = 3'h2;
   localparam [2:0] ST_WAIT_DAC = 3'h3;
   localparam [2:0] ST_RELEASE = 3'h4;

   localparam integer ACK_LAST_FULL = `ACK_CYCLES - 1;
   localparam integer SETTLE_LAST_FULL = `SETTLE_CYCLES - 1;
   // Both counts fit their counters; the part-selects make the cut explicit
   localparam [9:0] ACK_LAST = ACK_LAST_FULL[9:0];
   localparam [6:0] SETTLE_LAST = SETTLE_LAST_FULL[6:0];
   localparam [9:0] ACK_ZERO = 10'h000;
   localparam [6:0] SETTLE_ZERO = 7'h00;

   reg [7:0] data_reg;
   reg strobe_bit;
   reg strobe_prev;
   reg init_bit;
   reg select_input_bit;
   reg interrupt_enable_bit;
   reg [2:0] state;
   reg addr_phase;
   reg addressed;
   reg [6:0] settle_cnt;
   reg ack_n;
   reg [9:0] ack_cnt;
   reg soft_init;

   wire wr_data;
   wire wr_ctl;
   wire strobe_rise;
   wire init_fall;
   wire buf_rst;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [7:0] buf_out_data;
   wire take_data;
   wire busy;
   wire [7:0] status_value;
   wire [7:0] listen_addr;

   assign wr_data = i_io_wr & (i_io_addr == `OFS_DATA);
   assign wr_ctl = i_io_wr & (i_io_addr == `OFS_CONTROL);

   // Host data byte; held until the next write to the data offset
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         data_reg <= `DATA_RESET;
      end else if (wr_data) begin
         data_reg <= i_io_wdata;
      end
   end

   // Control bits; 7..5 and the linefeed bit are not stored at all,
   // since nothing in this bridge has a use for them
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         strobe_bit <= 1'b0;
         init_bit <= 1'b0;
         select_input_bit <= 1'b0;
         interrupt_enable_bit <= 1'b0;
      end else if (wr_ctl) begin
         strobe_bit <= i_io_wdata[`CTL_STROBE];
         init_bit <= i_io_wdata[`CTL_INIT];
         select_input_bit <= i_io_wdata[`CTL_SELECT_INPUT];
         interrupt_enable_bit <= i_io_wdata[`CTL_INTERRUPT_ENABLE];
      end
   end

   // Edge detectors on the stored strobe and init bits. The register
   // is already in the core domain, so one history stage suffices.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         strobe_prev <= 1'b0;
         soft_init <= 1'b0;
      end else begin
         strobe_prev <= strobe_bit;
         soft_init <= init_fall;
      end
   end

   assign strobe_rise = strobe_bit & ~strobe_prev;
   // Init takes effect when the bit goes back to zero, after the set
   assign init_fall = wr_ctl & init_bit & ~i_io_wdata[`CTL_INIT];
   assign buf_rst = i_rst | soft_init;

   // Buffer sits between the strobe and the handshake, so the host
   // can queue a byte while a slow listener finishes the previous one;
   // its entries are the secondary latch, filled on each strobe rising edge that finds one free
   byte_buffer2 u_buffer (
      .i_core_clk (i_core_clk),
      .i_rst (buf_rst),
      .i_in_valid (strobe_rise),
      .o_in_ready (buf_in_ready),
      .i_in_data (data_reg),
      .o_out_valid (buf_out_valid),
      .i_out_ready (take_data),
      .o_out_data (buf_out_data)
   );

   assign listen_addr = {`LISTEN_BASE, i_printer_addr};
   // Pop the data byte only when it is the one about to be sourced
   assign take_data = (state == ST_IDLE) & buf_out_valid &
                      select_input_bit & addressed;

   // Source handshake engine; a new byte is not started while select input is off
   // because the data lines may not be driven then
   always @(posedge i_core_clk) begin
      if (buf_rst) begin
         state <= ST_IDLE;
         addr_phase <= 1'b0;
         addressed <= 1'b0;
         settle_cnt <= SETTLE_ZERO;
         o_dio_out <= `READ_ZERO;
         o_atn <= 1'b0;
         o_dav <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               settle_cnt <= SETTLE_ZERO;
               if (buf_out_valid & select_input_bit) begin
                  state <= ST_SETTLE;
                  if (!addressed) begin
                     addr_phase <= 1'b1;
                     o_atn <= 1'b1;
                     o_dio_out <= listen_addr;
                  end else begin
                     addr_phase <= 1'b0;
                     o_dio_out <= buf_out_data;
                  end
               end
            end
            ST_SETTLE: begin
               // Data and ATN must be stable before DAV is offered
               if (settle_cnt == SETTLE_LAST) begin
                  state <= ST_WAIT_RFD;
               end else begin
                  settle_cnt <= settle_cnt + 7'h01;
               end
            end
            ST_WAIT_RFD: begin
               if (!i_nrfd) begin
                  o_dav <= 1'b1;
                  state <= ST_WAIT_DAC;
               end
            end
            ST_WAIT_DAC: begin
               if (!i_ndac) begin
                  o_dav <= 1'b0;
                  state <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               state <= ST_IDLE;
               if (addr_phase) begin
                  addressed <= 1'b1;
                  o_atn <= 1'b0;
                  addr_phase <= 1'b0;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Drive enable is registered, so it drops one cycle after the
   // select bit clears; a handshake under way still completes with the lines released
   always @(posedge i_core_clk) begin
      if (buf_rst) begin
         o_dio_oe <= 1'b0;
      end else begin
         o_dio_oe <= select_input_bit & (state != ST_IDLE);
      end
   end

   // Acknowledge pulse after the listener accepts a data byte
   always @(posedge i_core_clk) begin
      if (buf_rst) begin
         ack_n <= 1'b1;
         ack_cnt <= ACK_ZERO;
      end else if (state == ST_WAIT_DAC && !i_ndac && !addr_phase) begin
         ack_n <= 1'b0;
         ack_cnt <= ACK_ZERO;
      end else if (!ack_n) begin
         if (ack_cnt == ACK_LAST) begin
            ack_n <= 1'b1;
         end else begin
            ack_cnt <= ack_cnt + 10'h001;
         end
      end
   end

   // Interrupt holds from the trailing edge of acknowledge until the
   // handler clears the enable or the next byte is strobed; a level
   // suits the edge-sensitive host controller without a pulse width
   always @(posedge i_core_clk) begin
      if (buf_rst) begin
         o_irq <= 1'b0;
      end else if (!ack_n && ack_cnt == ACK_LAST &&
                   interrupt_enable_bit) begin
         o_irq <= 1'b1;
      end else if (!interrupt_enable_bit || strobe_rise) begin
         o_irq <= 1'b0;
      end
   end

   // Busy is the buffer's back-pressure when full, or the addressed listener holding NRFD, as seen by the host
   assign busy = ~buf_in_ready | (addressed & i_nrfd);

   assign status_value = {~busy, ack_n, i_srq_option & i_srq, ~o_atn,
                          1'b1, 3'h0};

   // Read data is registered; the control offset reads as zero
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_io_rdata <= `READ_ZERO;
      end else if (i_io_rd) begin
         case (i_io_addr)
            `OFS_DATA: begin
               o_io_rdata <= data_reg;
            end
            `OFS_STATUS: begin
               o_io_rdata <= status_value;
            end
            `OFS_CONTROL: begin
               o_io_rdata <= `READ_ZERO;
            end
            default: begin
               o_io_rdata <= `READ_ZERO;
            end
         endcase
      end
   end

endmodule // parallel_port_gpib_bridge

`default_nettype wire

// ==== sim/bridge_props.sv ====
/* Concurrent checks on the bridge's ports.
   Assumes one clock and the synchronous active-high reset. */
`default_nettype none
`include "bridge_defines.vh"
module bridge_props (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [1:0] i_io_addr,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [7:0] i_io_wdata,
   input wire logic [7:0] o_io_rdata,
   input wire logic o_irq,
   input wire logic [4:0] i_printer_addr,
   input wire logic i_srq_option,
   input wire logic i_srq,
   input wire logic i_nrfd,
   input wire logic i_ndac,
   input wire logic [7:0] o_dio_out,
   input wire logic o_dio_oe,
   input wire logic o_atn,
   input wire logic o_dav
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctl;
   logic [7:0] dat;
   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   // Shadows of host writes; the control register cannot be read back
   always @(posedge i_core_clk) begin
      if (i_rst) ctl <= 8'h00;
      else if (i_io_wr && i_io_addr == 2'h2) ctl <= i_io_wdata;
      if (i_rst) dat <= 8'h00;
      else if (i_io_wr && i_io_addr == 2'h0) dat <= i_io_wdata;
   end
   chk_ctl_read_zero:
   assert property (i_io_rd && i_io_addr == 2'h2 |=> o_io_rdata == 8'h00)
      else $error("control read not zero");
   chk_data_read_back:
   assert property (i_io_rd && i_io_addr == 2'h0
      |=> o_io_rdata == $past(dat)) else $error("data read wrong");
   chk_oe_needs_select:
   assert property (!ctl[3] && !$past(ctl[3]) |-> !o_dio_oe)
      else $error("data lines driven unselected");
   chk_dav_after_ready:
   assert property ($rose(o_dav) |-> $past(!i_nrfd))
      else $error("dav raised while not ready");
   chk_dav_release:
   assert property (o_dav && !i_ndac |=> !o_dav) else $error("dav held");
   chk_listen_addr:
   assert property ($rose(o_dav) && o_atn
      |-> o_dio_out == {`LISTEN_BASE, i_printer_addr})
      else $error("bad listen address");
   chk_irq_after_ack:
   assert property ($fell(o_dav) && !$past(o_atn) && ctl[4]
      |-> !o_irq [*8] ##[1:700] o_irq) else $error("no interrupt");
   chk_irq_gated:
   assert property (!ctl[4] && !$past(ctl[4]) |-> !o_irq)
      else $error("interrupt while disabled");
   cov_address: cover property ($rose(o_dav) && o_atn);
   cov_irq: cover property ($rose(o_irq));
   cov_busy: cover property (i_io_rd && i_io_addr == 2'h1 ##1 !o_io_rdata[7]);
endmodule // bridge_props
bind parallel_port_gpib_bridge bridge_props bridge_props_i (.i_core_clk,
   .i_rst, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata, .o_irq,
   .i_printer_addr, .i_srq_option, .i_srq, .i_nrfd, .i_ndac, .o_dio_out,
   .o_dio_oe, .o_atn, .o_dav);
`default_nettype wire

// ==== sim/listener_model.sv ====
/* Listener on the instrument bus side; logs every accepted byte.
   Assumes logical levels (1 = asserted) and the bridge's clock. */
`default_nettype none
module listener_model (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_dav,
   input wire logic i_atn,
   input wire logic [7:0] i_dio,
   input wire logic i_stall,
   input wire logic i_slow,
   output logic o_nrfd,
   output logic o_ndac
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] cnt;
   logic [8:0] words[$];
   // Not ready while stalled or while a byte is offered; the slow
   // setting stretches acceptance so the source must really wait
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_nrfd <= 1'b1;
         o_ndac <= 1'b1;
         cnt <= 6'h00;
      end else begin
         o_nrfd <= i_stall | i_dav;
         if (!i_dav) begin
            o_ndac <= 1'b1;
            cnt <= 6'h00;
         end else if (o_ndac && cnt == (i_slow ? 6'h28 : 6'h02)) begin
            o_ndac <= 1'b0;
            words.push_back({i_atn, i_dio});
         end else begin
            cnt <= cnt + 6'h01;
         end
      end
   end
endmodule // listener_model
`default_nettype wire

// ==== sim/parallel_port_gpib_bridge_tb.sv ====
/* Bench for the bridge: host register tasks and a bus listener.
   Assumes the bridge, its defines and the listener model. */
`default_nettype none
module parallel_port_gpib_bridge_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic srq = 1'b0;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic [4:0] paddr = 5'h0A;
   wire [7:0] rdata;
   wire [7:0] dio;
   wire irq, oe, atn, dav, nrfd, ndac;
   int miscompares = 0;
   int samples_checked = 0;
   int n;
   int since_dav = 0;
   always #4 clk = ~clk;
   // Cycles since DAV last stood; at the interrupt it spans the pulse
   always @(posedge clk) begin
      if (dav) since_dav <= 0;
      else since_dav <= since_dav + 1;
   end
   parallel_port_gpib_bridge parallel_port_gpib_bridge_i (
      .i_core_clk(clk), .i_rst(rst), .i_io_addr(addr), .i_io_wr(wr),
      .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata), .o_irq(irq),
      .i_printer_addr(paddr), .i_srq_option(srq), .i_srq(srq),
      .i_nrfd(nrfd), .i_ndac(ndac), .o_dio_out(dio), .o_dio_oe(oe),
      .o_atn(atn), .o_dav(dav));
   // Released data lines read as idle, never as the last byte
   listener_model listener_model_i (
      .i_core_clk(clk), .i_rst(rst), .i_dav(dav), .i_atn(atn),
      .i_dio(oe ? dio : 8'h00), .i_stall(stall), .i_slow(slow),
      .o_nrfd(nrfd), .o_ndac(ndac));
   task automatic print_verdict;
      $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Host cycles: one-cycle strobes, launched just after an edge
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1 wr = 1'b0;
   endtask
   task automatic rd_raw(input logic [1:0] a);
      @(posedge clk);
      #1 addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1 rd = 1'b0;
   endtask
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
      rd_raw(a);
      check(rdata, exp);
   endtask
   // Strobe pulse of about 1.6 us; the wait for not busy can be skipped
   task automatic send(input logic [7:0] d, input logic [7:0] c,
                       input logic wait_rdy);
      wr_reg(2'h0, d);
      for (int i = 0; i < 500 && wait_rdy; i++) begin
         rd_raw(2'h1);
         if (rdata[7] === 1'b1) break;
      end
      if (wait_rdy) check(rdata[7], 1);
      if (wait_rdy && rdata[7] !== 1'b1) print_verdict();
      wr_reg(2'h2, c | 8'h01);
      repeat (200) @(posedge clk);
      wr_reg(2'h2, c);
   endtask
   task automatic next_word(input logic [8:0] exp);
      for (int i = 0; i < 2000 && listener_model_i.words.size() == 0; i++)
         @(posedge clk);
      if (listener_model_i.words.size() == 0) begin
         miscompares++;
         print_verdict();
      end else begin
         check(listener_model_i.words.pop_front(), exp);
      end
   endtask
   // Main sequence: registers, addressing, interrupt, select, buffer, init
   initial begin
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      rd_chk(2'h1, 8'hD8);
      srq = 1'b1;
      wr_reg(2'h0, 8'hA5);
      wr_reg(2'h3, 8'h5A);
      rd_chk(2'h0, 8'hA5);
      rd_chk(2'h2, 8'h00);
      rd_chk(2'h3, 8'h00);
      send(8'h3C, 8'h18, 1'b1);
      next_word(9'h12A);
      next_word(9'h03C);
      // Sample after the edge so the interrupt is settled; 625 cycles
      // of 8 ns make the 5 us minimum acknowledge pulse
      for (n = 0; n < 2000 && irq !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      check(since_dav >= 625, 1);
      check(irq, 1);
      if (irq !== 1'b1) print_verdict();
      wr_reg(2'h2, 8'h08);
      repeat (2) @(posedge clk);
      check(irq, 0);
      send(8'h5A, 8'hEA, 1'b1);
      next_word(9'h05A);
      repeat (700) @(posedge clk);
      check(listener_model_i.words.size(), 0);
      check(irq, 0);
      send(8'h77, 8'hE2, 1'b1);
      repeat (300) @(posedge clk);
      check(listener_model_i.words.size(), 0);
      check(oe, 0);
      wr_reg(2'h2, 8'h08);
      next_word(9'h077);
      repeat (700) @(posedge clk);
      #1 stall = 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(2'h1, 8'h78);
      send(8'h11, 8'h08, 1'b0);
      send(8'h22, 8'h08, 1'b0);
      send(8'h33, 8'h08, 1'b0);
      send(8'h44, 8'h08, 1'b0);
      stall = 1'b0;
      next_word(9'h011);
      next_word(9'h022);
      next_word(9'h033);
      repeat (300) @(posedge clk);
      check(listener_model_i.words.size(), 0);
      wr_reg(2'h2, 8'h0C);
      wr_reg(2'h2, 8'h08);
      slow = 1'b1;
      send(8'h99, 8'h08, 1'b1);
      next_word(9'h12A);
      next_word(9'h099);
      print_verdict();
   end
endmodule // parallel_port_gpib_bridge_tb
`default_nettype wire
